// ### shared/flrl_consts.svh
// Named offsets, field values, sizes and timing figures of the fault level, reset and log block.
`ifndef FLRL_CONSTS_SVH
`define FLRL_CONSTS_SVH

`define FLRL_OFS_RESET_CMD   12'h000
`define FLRL_OFS_SYS_INIT    12'h004
`define FLRL_OFS_LOG_SELECT  12'h008
`define FLRL_OFS_LOG_CODE    12'h00C
`define FLRL_OFS_STATUS_LO   12'h010
`define FLRL_OFS_STATUS_HI   12'h02C
`define FLRL_OFS_CONTROL     12'h030
`define FLRL_OFS_ACTIVE      12'h034

`define FLRL_CMD_NONE        16'h0000
`define FLRL_CMD_RESET       16'h0001
`define FLRL_INIT_MODE_A     16'h0001
`define FLRL_INIT_MODE_B     16'h0002

`define FLRL_NIB_NR1         4'h0
`define FLRL_NIB_R1          4'h2
`define FLRL_NIB_C2          4'h6
`define FLRL_NIB_C3          4'hE

`define FLRL_LOG_DEPTH       10
`define FLRL_DUP_WINDOW      5
`define FLRL_STATUS_WORDS    8

`define FLRL_CLK_MHZ         50
`define FLRL_DEB_TIME_US     3000

`endif

// ### shared/flrl_pkg.sv
// Types shared by the fault level, reset and log block.
`default_nettype none
package flrl_pkg;

	// Severity kind of a fault or warning, most severe first.
	typedef enum logic [1:0] {
		FLRL_NR1 = 2'b00,
		FLRL_R1  = 2'b01,
		FLRL_C2  = 2'b10,
		FLRL_C3  = 2'b11
	} flrl_kind_t;

	// One event reported by the drive.
	typedef struct packed {
		logic       valid;
		flrl_kind_t kind;
		logic [11:0] code;
	} flrl_evt_t;

	// Eight drive status values caught with an event.
	typedef struct packed {
		logic [7:0][15:0] vals;
	} flrl_snap_t;

endpackage : flrl_pkg
`default_nettype wire

// ### logic/flrl_log_mem.sv
// Status snapshot memory of the event history, with registered read data.
`default_nettype none
module flrl_log_mem #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 10,
	parameter int AW    = 4
) (
	input  wire logic             i_clk,   // System clock.
	input  wire logic             i_we,    // Write strobe.
	input  wire logic [AW-1:0]    i_waddr, // Write entry.
	input  wire logic [WIDTH-1:0] i_wdata, // Write data.
	input  wire logic [AW-1:0]    i_raddr, // Read entry.
	output logic      [WIDTH-1:0] o_rdata  // Registered read data.
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Stores one snapshot per write strobe.
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Reads the selected entry one cycle later.
	always_ff @(posedge i_clk)
	begin
		o_rdata <= mem[i_raddr];
	end

endmodule : flrl_log_mem
`default_nettype wire

// ### logic/flrl_top.sv
// Fault ranking, reset gating, debounced reset input and event history with APB registers.
//
// Local design decisions: register access over APB and the placing of the registers.
`include "flrl_consts.svh"
`default_nettype none
module flrl_top #(
	parameter int DEB_CYCLES = `FLRL_DEB_TIME_US * `FLRL_CLK_MHZ + 1
) (
	input  wire logic                 I_CLK,      // System clock, 50 MHz.
	input  wire logic                 I_RST,      // Synchronous reset, active high.
	input  wire logic                 I_PSEL,     // APB select.
	input  wire logic                 I_PENABLE,  // APB enable.
	input  wire logic                 I_PWRITE,   // APB direction.
	input  wire logic [11:0]          I_PADDR,    // APB byte address.
	input  wire logic [31:0]          I_PWDATA,   // APB write data.
	output logic      [31:0]          O_PRDATA,   // APB read data.
	output logic                      O_PREADY,   // APB ready.
	output logic                      O_PSLVERR,  // APB error on unmapped address.
	input  wire flrl_pkg::flrl_evt_t  I_EVT,      // Event from the drive, one cycle.
	input  wire flrl_pkg::flrl_snap_t I_SNAP,     // Drive status at the event.
	input  wire logic                 I_SERVO_EN, // Servo enable level.
	input  wire logic                 I_ALARM_CLEAR_IN, // Reset input level, active high.
	output logic      [15:0]          O_ACTIVE_CODE, // Code word of most severe active event.
	output logic                      O_STOP_REQ, // Class one or two fault active.
	output logic                      O_WARNING   // Class three warning active.
);

	localparam int LOGD = `FLRL_LOG_DEPTH;

	// Builds the logged code word from kind and code.
	function automatic logic [15:0] code_word(input flrl_pkg::flrl_kind_t k, input logic [11:0] c);
		logic [3:0] nib;
		nib = `FLRL_NIB_C3;
		unique case (k)
			flrl_pkg::FLRL_NR1: nib = `FLRL_NIB_NR1;
			flrl_pkg::FLRL_R1:  nib = `FLRL_NIB_R1;
			flrl_pkg::FLRL_C2:  nib = `FLRL_NIB_C2;
			flrl_pkg::FLRL_C3:  nib = `FLRL_NIB_C3;
		endcase
		return {nib, c};
	endfunction : code_word

	// Ring slot that lies back + 1 entries before the write pointer.
	function automatic logic [3:0] ring_idx(input logic [3:0] wp, input logic [3:0] back);
		logic [4:0] t;
		t = 5'(wp) + 5'(LOGD) - 5'd1 - 5'(back);
		if (t >= 5'(LOGD))
		begin
			t = t - 5'(LOGD);
		end
		return t[3:0];
	endfunction : ring_idx

	// Bus handshake and register state.
	logic        cmd_q;
	logic        hs_map;
	logic [3:0]  sel;
	logic        access;
	logic        wr_en;
	logic        init_clr;
	logic        clr;
	logic        di_fire;
	logic [17:0] di_cnt;

	assign access = I_PSEL & I_PENABLE & ~O_PREADY;
	assign wr_en  = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
	assign init_clr = wr_en && I_PADDR == `FLRL_OFS_SYS_INIT &&
		(I_PWDATA[15:0] == `FLRL_INIT_MODE_A || I_PWDATA[15:0] == `FLRL_INIT_MODE_B);
	assign clr = cmd_q | di_fire;

	// Reset command: a write of 1 requests, and the bit drops after one cycle.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			cmd_q <= 1'b0;
		else if (wr_en && I_PADDR == `FLRL_OFS_RESET_CMD && I_PWDATA[15:0] == `FLRL_CMD_RESET)
			cmd_q <= 1'b1;
		else
			cmd_q <= 1'b0;
	end

	// Selector and reset input mapping.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			sel    <= 4'h0;
			hs_map <= 1'b0;
		end
		else if (wr_en && I_PADDR == `FLRL_OFS_LOG_SELECT)
			sel <= I_PWDATA[3:0];
		else if (wr_en && I_PADDR == `FLRL_OFS_CONTROL)
			hs_map <= I_PWDATA[0];
	end

	// Reset input filter: counts a stable active level and fires once past the limit.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST || !I_ALARM_CLEAR_IN || hs_map)
		begin
			di_cnt  <= 18'h00000;
			di_fire <= 1'b0;
		end
		else if (di_cnt != 18'(DEB_CYCLES))
		begin
			di_cnt  <= di_cnt + 18'h00001;
			di_fire <= (di_cnt == 18'(DEB_CYCLES - 1));
		end
		else
			di_fire <= 1'b0;
	end

	// Active events, one slot per kind; a new event wins over a clear.
	logic [3:0]       act_v;
	logic [3:0][11:0] act_code;

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			act_v    <= 4'h0;
			act_code <= '0;
		end
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (I_EVT.valid && I_EVT.kind == flrl_pkg::flrl_kind_t'(k))
				begin
					act_v[k]    <= 1'b1;
					act_code[k] <= I_EVT.code;
				end
				else if (clr && k == int'(flrl_pkg::FLRL_C3))
					act_v[k] <= 1'b0;
				else if (clr && !I_SERVO_EN && (k == int'(flrl_pkg::FLRL_R1) || k == int'(flrl_pkg::FLRL_C2)))
					act_v[k] <= 1'b0;
			end
		end
	end

	// Severity report; warnings never raise the stop request.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_ACTIVE_CODE <= 16'h0000;
			O_STOP_REQ    <= 1'b0;
			O_WARNING     <= 1'b0;
		end
		else
		begin
			O_STOP_REQ <= |act_v[2:0];
			O_WARNING  <= act_v[3];
			if (act_v[0])
				O_ACTIVE_CODE <= code_word(flrl_pkg::FLRL_NR1, act_code[0]);
			else if (act_v[1])
				O_ACTIVE_CODE <= code_word(flrl_pkg::FLRL_R1, act_code[1]);
			else if (act_v[2])
				O_ACTIVE_CODE <= code_word(flrl_pkg::FLRL_C2, act_code[2]);
			else if (act_v[3])
				O_ACTIVE_CODE <= code_word(flrl_pkg::FLRL_C3, act_code[3]);
			else
				O_ACTIVE_CODE <= 16'h0000;
		end
	end

	// History ring: codes in flops for the repeat check, snapshots in memory.
	logic [LOGD-1:0][15:0] log_code;
	logic [3:0]  wp;
	logic [3:0]  cnt;
	logic [3:0]  base_wp;
	logic [3:0]  base_cnt;
	logic [15:0] new_word;
	logic        dup;
	logic        log_we;

	assign base_wp  = init_clr ? 4'h0 : wp;
	assign base_cnt = init_clr ? 4'h0 : cnt;
	assign new_word = code_word(I_EVT.kind, I_EVT.code);
	assign log_we   = I_EVT.valid && !dup;

	// Compares the new code with the latest entries still held.
	always_comb
	begin
		dup = 1'b0;
		for (int k = 0; k < `FLRL_DUP_WINDOW; k++)
		begin
			if (4'(k) < base_cnt && log_code[ring_idx(base_wp, 4'(k))] == new_word)
				dup = 1'b1;
		end
	end

	// Writes a new entry and advances the pointer; init erases the history.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			wp       <= 4'h0;
			cnt      <= 4'h0;
			log_code <= '0;
		end
		else if (log_we)
		begin
			log_code[base_wp] <= new_word;
			wp  <= (base_wp == 4'(LOGD - 1)) ? 4'h0 : base_wp + 4'h1;
			cnt <= (base_cnt == 4'(LOGD)) ? base_cnt : base_cnt + 4'h1;
		end
		else if (init_clr)
		begin
			wp  <= 4'h0;
			cnt <= 4'h0;
		end
	end

	// Readout of the selected entry, zero when it holds no event.
	logic [15:0]         sel_code;
	logic                sel_ok;
	flrl_pkg::flrl_snap_t sel_snap;

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			sel_code <= 16'h0000;
			sel_ok   <= 1'b0;
		end
		else
		begin
			sel_ok   <= sel < cnt;
			sel_code <= (sel < cnt) ? log_code[ring_idx(wp, sel)] : 16'h0000;
		end
	end

	flrl_log_mem #(
		.WIDTH (16 * `FLRL_STATUS_WORDS),
		.DEPTH (LOGD),
		.AW    (4)
	) u_mem (
		.i_clk   (I_CLK),
		.i_we    (log_we),
		.i_waddr (base_wp),
		.i_wdata (I_SNAP.vals),
		.i_raddr (ring_idx(wp, sel)),
		.o_rdata (sel_snap)
	);

	// APB answer: one wait state, read data and error registered at the access edge.
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h00000000;
			O_PSLVERR <= 1'b0;
		end
		else
		begin
			O_PREADY  <= access;
			O_PSLVERR <= 1'b0;
			if (access)
			begin
				O_PRDATA <= 32'h00000000;
				if (I_PADDR == `FLRL_OFS_RESET_CMD)
					O_PRDATA <= {31'h00000000, cmd_q};
				else if (I_PADDR == `FLRL_OFS_SYS_INIT)
					O_PRDATA <= 32'h00000000;
				else if (I_PADDR == `FLRL_OFS_LOG_SELECT)
					O_PRDATA <= {28'h0000000, sel};
				else if (I_PADDR == `FLRL_OFS_LOG_CODE)
					O_PRDATA <= {16'h0000, sel_code};
				else if (I_PADDR >= `FLRL_OFS_STATUS_LO && I_PADDR <= `FLRL_OFS_STATUS_HI && I_PADDR[1:0] == 2'b00)
					O_PRDATA <= sel_ok ? {16'h0000, sel_snap.vals[3'(I_PADDR[4:2] - 3'h4)]} : 32'h00000000;
				else if (I_PADDR == `FLRL_OFS_CONTROL)
					O_PRDATA <= {31'h00000000, hs_map};
				else if (I_PADDR == `FLRL_OFS_ACTIVE)
					O_PRDATA <= {12'h000, act_v, O_ACTIVE_CODE};
				else
					O_PSLVERR <= 1'b1;
			end
		end
	end

	// Checks on the behaviour above.
	sequence s_clear_warn;
		clr && !(I_EVT.valid && I_EVT.kind == flrl_pkg::FLRL_C3);
	endsequence

	sequence s_gated_clear;
		clr && I_SERVO_EN && act_v[1] && !I_RST;
	endsequence

	a_warn_clear_any: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_clear_warn |=> !act_v[3]) else $error("warning not cleared by reset request");

	a_gate_servo_on: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_gated_clear |=> act_v[1]) else $error("class one fault cleared with servo enabled");

	a_nonreset_latch: assert property (@(posedge I_CLK) disable iff (I_RST)
		act_v[0] |=> act_v[0]) else $error("non-resettable fault was cleared");

	a_cmd_self_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
		cmd_q |=> !cmd_q) else $error("reset command did not return to zero");

	a_filter_min_time: assert property (@(posedge I_CLK) disable iff (I_RST)
		di_fire |-> $past(I_ALARM_CLEAR_IN) && di_cnt == 18'(DEB_CYCLES)) else $error("reset input fired too early");

	a_fast_map_block: assert property (@(posedge I_CLK) disable iff (I_RST)
		hs_map |=> !di_fire) else $error("reset from high-speed input mapping");

	a_repeat_skip: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVT.valid && dup && !init_clr |=> $stable(wp) && $stable(cnt)) else $error("repeated event logged");

	a_log_advance: assert property (@(posedge I_CLK) disable iff (I_RST)
		log_we && !init_clr && cnt < 4'(LOGD) |=> cnt == $past(cnt) + 4'h1) else $error("history count did not advance");

	a_init_erase: assert property (@(posedge I_CLK) disable iff (I_RST)
		init_clr && !I_EVT.valid |=> cnt == 4'h0 ##1 sel_code == 16'h0000) else $error("history not erased");

	a_warn_no_stop: assert property (@(posedge I_CLK) disable iff (I_RST)
		act_v == 4'b1000 |=> !O_STOP_REQ && O_WARNING) else $error("warning forced a stop");

	a_worst_first: assert property (@(posedge I_CLK) disable iff (I_RST)
		act_v[0] |=> O_ACTIVE_CODE[15:12] == `FLRL_NIB_NR1) else $error("most severe code not reported");

endmodule : flrl_top
`default_nettype wire

// ### sim/flrl_host.sv
// APB host model that issues register transfers to the block.
`default_nettype none
module flrl_host (
	input  wire logic        i_clk,     // Clock.
	output logic             o_psel,    // Select.
	output logic             o_penable, // Enable.
	output logic             o_pwrite,  // Direction.
	output logic [11:0]      o_paddr,   // Address.
	output logic [31:0]      o_pwdata,  // Write data.
	input  wire logic [31:0] i_prdata,  // Read data.
	input  wire logic        i_pready,  // Ready.
	input  wire logic        i_pslverr  // Error.
);
	timeunit 1ns;
	timeprecision 1ns;

	// The bus is idle at time zero.
	initial
	begin
		o_psel = 1'h0;
		o_penable = 1'h0;
		o_pwrite = 1'h0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0;
	end

	// One transfer; the request stands until ready is seen at an edge, however long that takes.
	// Only the bench watchdog ends a wait that never completes.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge i_clk);
		o_psel <= 1'h1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'h1;
		do
		begin
			@(posedge i_clk);
		end
		while (i_pready !== 1'h1);
		q = i_prdata;
		e = i_pslverr;
		o_psel <= 1'h0;
		o_penable <= 1'h0;
	endtask : xfer
endmodule : flrl_host
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the fault level, reset and log block.
`include "flrl_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEB = 20;
	logic                  clk;
	logic                  rst;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	flrl_pkg::flrl_evt_t   evt;
	flrl_pkg::flrl_snap_t  snap;
	logic                  servo_en;
	logic                  alarm_in;
	logic [15:0]           act_code;
	logic                  stop_req;
	logic                  warning;
	logic [31:0]           rdq;
	logic                  rde;
	int                    miscompares;
	int                    compares;

	flrl_top #(.DEB_CYCLES(DEB)) dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVT(evt),
		.I_SNAP(snap), .I_SERVO_EN(servo_en), .I_ALARM_CLEAR_IN(alarm_in),
		.O_ACTIVE_CODE(act_code), .O_STOP_REQ(stop_req), .O_WARNING(warning));
	flrl_host host (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr));

	// Free running 50 MHz clock.
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// Register write and checked register read.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'h1, a, d, rdq, rde);
	endtask : wr
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
		host.xfer(1'h0, a, 32'h0, rdq, rde);
		chk(nm, ex, rdq);
	endtask : rdc

	// Selects a history entry and checks its code word.
	task automatic lc(input logic [31:0] s, input logic [31:0] ex);
		wr(`FLRL_OFS_LOG_SELECT, s);
		rdc("log code", `FLRL_OFS_LOG_CODE, ex);
	endtask : lc

	// One event pulse with a snapshot that tags each word by index.
	task automatic ev(input flrl_pkg::flrl_kind_t k, input logic [11:0] c);
		@(posedge clk);
		evt <= '{1'h1, k, c};
		for (int j = 0; j < 8; j++)
			snap.vals[j] <= {4'(j), c};
		@(posedge clk);
		evt.valid <= 1'h0;
		repeat (4) @(posedge clk);
	endtask : ev

	// Holds the reset input high for n cycles.
	task automatic pulse(input int n);
		@(posedge clk);
		alarm_in <= 1'h1;
		repeat (n) @(posedge clk);
		alarm_in <= 1'h0;
		repeat (4) @(posedge clk);
	endtask : pulse

	// Values after reset and an unmapped access.
	task automatic t_reset();
		rdc("reset cmd", `FLRL_OFS_RESET_CMD, 32'h0);
		rdc("empty code", `FLRL_OFS_LOG_CODE, 32'h0);
		rdc("unmapped", 12'h100, 32'h0);
		chk("slverr", 32'h1, {31'h0, rde});
		$display("test reset done");
	endtask : t_reset

	// Class encoding, ranking and history readout.
	task automatic t_class();
		ev(flrl_pkg::FLRL_C3, 12'h110);
		chk("active", 32'hE110, {16'h0, act_code});
		chk("stop", 32'h0, {31'h0, stop_req});
		ev(flrl_pkg::FLRL_C2, 12'h121);
		chk("active", 32'h6121, {16'h0, act_code});
		ev(flrl_pkg::FLRL_R1, 12'h130);
		chk("active", 32'h2130, {16'h0, act_code});
		ev(flrl_pkg::FLRL_NR1, 12'h101);
		chk("active", 32'h0101, {16'h0, act_code});
		rdc("kinds", `FLRL_OFS_ACTIVE, 32'h000F0101);
		lc(32'h0, 32'h0101);
		lc(32'h1, 32'h2130);
		lc(32'h3, 32'hE110);
		rdc("status lo", `FLRL_OFS_STATUS_LO, 32'h0110);
		rdc("status hi", `FLRL_OFS_STATUS_HI, 32'h7110);
		$display("test class done");
	endtask : t_class

	// Reset command gated by servo enable.
	task automatic t_clear();
		wr(`FLRL_OFS_RESET_CMD, 32'h1);
		rdc("reset cmd", `FLRL_OFS_RESET_CMD, 32'h0);
		chk("warning", 32'h0, {31'h0, warning});
		rdc("kinds", `FLRL_OFS_ACTIVE, 32'h00070101);
		servo_en <= 1'h0;
		wr(`FLRL_OFS_RESET_CMD, 32'h1);
		repeat (4) @(posedge clk);
		rdc("kinds", `FLRL_OFS_ACTIVE, 32'h00010101);
		chk("stop", 32'h1, {31'h0, stop_req});
		lc(32'h0, 32'h0101);
		$display("test clear done");
	endtask : t_clear

	// History depth, repeat suppression and erase.
	task automatic t_log();
		wr(`FLRL_OFS_SYS_INIT, 32'h1);
		lc(32'h0, 32'h0);
		for (int i = 0; i < 11; i++)
			ev(flrl_pkg::FLRL_C3, 12'h200 + 12'(i));
		lc(32'h9, 32'hE201);
		ev(flrl_pkg::FLRL_C3, 12'h206);
		lc(32'h1, 32'hE209);
		ev(flrl_pkg::FLRL_C3, 12'h205);
		lc(32'h0, 32'hE205);
		wr(`FLRL_OFS_SYS_INIT, 32'h2);
		lc(32'h0, 32'h0);
		$display("test log done");
	endtask : t_log

	// Filtered reset input, short, ignored mapping and long.
	task automatic t_input();
		servo_en <= 1'h1;
		pulse(DEB - 5);
		chk("warning", 32'h1, {31'h0, warning});
		wr(`FLRL_OFS_CONTROL, 32'h1);
		rdc("control", `FLRL_OFS_CONTROL, 32'h1);
		pulse(DEB + 5);
		chk("warning", 32'h1, {31'h0, warning});
		wr(`FLRL_OFS_CONTROL, 32'h0);
		pulse(DEB + 5);
		chk("warning", 32'h0, {31'h0, warning});
		$display("test input done");
	endtask : t_input

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// Cuts a hang short.
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	// Main sequence.
	initial
	begin
		miscompares = 0;
		compares = 0;
		rst = 1'h1;
		evt = '0;
		snap = '0;
		servo_en = 1'h1;
		alarm_in = 1'h0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_class();
		t_clear();
		t_log();
		t_input();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
